// ---- verilog/dslfs_top.sv ----
// frame sync, deactivation, micro-interruption, loopback and polarity logic
//
// Behaviour
// - sync machine runs only in modes 6, 7
// - from 6 via 7, two sync words give 0
// - misses in sync step from 1 to 5
// - sync word in states 1-5 returns to 0
// - sixth miss: state 6, pending deactivation, timer
// - deactivation timer expiry: deactivated, sync 0
// - resync via 7, or via 8 on realignment
// - quiet forces deactivated from all but inactive, transmitter silent
// - deactivated slave leaves only on signal absence
// - deactivated master: absence timer, then inactive
// - signal return clears absence timer
// - margin below -6 dB: freeze, time-out, timer
// - margin above -3 dB: return, adapt, realign
// - interruption timer expiry: go deactivated
// - timer unit 2048 bauds, expires past 255
// - analog loopback: receiver off, balance on, transmit
// - analog loopback only master, from inactive
// - digital loopback sends received data, frame pulses
// - digital loopback active framed only; unframed, its bit blocks reads
// - framed: polarity from framing signal, corrected
// - unframed: reversal bit 7 inverts polarity
`timescale 1ns/1ps
`include "dslfs_regs.svh"
module dslfs_top #(
  parameter int DEACT_FRAMES = 333,
  parameter int LOS_UNITS    = 80,
  parameter int LOS_PRE      = 2048
) (
  input  wire logic                   REF_CLK,
  input  wire logic                   RST_B,
  input  wire logic                   HSEL,
  input  wire logic [31:0]            HADDR,
  input  wire logic [1:0]             HTRANS,
  input  wire logic                   HWRITE,
  input  wire logic [2:0]             HSIZE,
  input  wire logic [31:0]            HWDATA,
  input  wire logic                   HREADY,
  output logic      [31:0]            HRDATA,
  output logic                        HREADYOUT,
  output logic                        HRESP,
  input  wire logic                   QUIET_PIN,
  input  wire logic                   BAUD_TICK,
  input  wire dslfs_pkg::dslfs_frame_t FRAME_IN,
  input  wire logic                   MARGIN_LOW,
  input  wire logic                   MARGIN_OK,
  input  wire logic                   SIGNAL_ABSENT,
  input  wire logic                   TRAIN_DONE,
  input  wire logic                   TRAIN_FAIL,
  input  wire logic                   RX_SIGN_IN,
  input  wire dslfs_pkg::dslfs_bit_t  TX_IN,
  input  wire dslfs_pkg::dslfs_bit_t  RX_IN,
  output dslfs_pkg::dslfs_bit_t       TX_OUT,
  output dslfs_pkg::dslfs_bit_t       RX_OUT,
  output logic                        RX_SIGN_OUT,
  output logic                        TX_ENABLE,
  output logic                        RX_INPUT_EN,
  output logic                        BALANCE_EN,
  output logic                        COEF_FREEZE,
  output logic                        PHASE_REALIGN,
  output logic                        LINK_ACTIVE
);

  // ****************************************************************
  // registers and state
  // ****************************************************************
  logic [7:0]               ctrl_reg;
  logic [7:0]               rev_reg;
  logic [7:0]               cfg_reg;
  logic [2:0]               ev_reg;
  logic [2:0]               ev_next;
  dslfs_pkg::dslfs_act_t    act_reg;
  dslfs_pkg::dslfs_act_t    act_next;
  dslfs_pkg::dslfs_act_t    ret_reg;
  dslfs_pkg::dslfs_sync_t   sync_reg;
  dslfs_pkg::dslfs_sync_t   sync_next;
  logic                     alb_reg;
  logic                     pol_reg;
  logic                     wr_pend_reg;
  logic [`DSLFS_ADDR_W-1:0] wr_addr_reg;

  logic framed;
  logic master;
  logic quiet;
  logic dlb_on;
  logic deact_done;
  logic los_done;
  logic mit_done;
  logic frame_step;
  logic addr_ok;

  assign framed = (cfg_reg[`DSLFS_CFG_MODE_MSB:`DSLFS_CFG_MODE_LSB] == `DSLFS_MODE_FR_A) ||
                  (cfg_reg[`DSLFS_CFG_MODE_MSB:`DSLFS_CFG_MODE_LSB] == `DSLFS_MODE_FR_B);
  assign master = cfg_reg[`DSLFS_CFG_MASTER];
  // pin in hardware control mode, register bit otherwise
  assign quiet  = cfg_reg[`DSLFS_CFG_HWCTL] ? QUIET_PIN : ctrl_reg[`DSLFS_CTL_QUIET];
  // frames only count while searching or holding sync in a framed mode
  assign frame_step = FRAME_IN.tick && framed &&
                      ((act_reg == dslfs_pkg::ACT_FRAMEDET) ||
                       (act_reg == dslfs_pkg::ACT_ACTIVE) ||
                       (act_reg == dslfs_pkg::ACT_PEND_DEACT));
  assign dlb_on = ctrl_reg[`DSLFS_CTL_DLB] && framed &&
                  ((act_reg == dslfs_pkg::ACT_ACTIVE) || (act_reg == dslfs_pkg::ACT_PEND_DEACT));
  assign addr_ok = HSEL && HREADY && HTRANS[1];

  // ****************************************************************
  // timers
  // ****************************************************************
  dslfs_timer #(.PRE(1), .LIMIT(DEACT_FRAMES)) u_deact (
    .REF_CLK (REF_CLK),
    .RST_B   (RST_B),
    .clr     (act_reg != dslfs_pkg::ACT_PEND_DEACT),
    .run     (1'b1),
    .tick    (FRAME_IN.tick),
    .done    (deact_done)
  );

  // absence timer restarts from zero whenever the far end shows signal
  dslfs_timer #(.PRE(LOS_PRE), .LIMIT(LOS_UNITS)) u_los (
    .REF_CLK (REF_CLK),
    .RST_B   (RST_B),
    .clr     ((act_reg != dslfs_pkg::ACT_DEACT) || !SIGNAL_ABSENT),
    .run     (master),
    .tick    (BAUD_TICK),
    .done    (los_done)
  );

  // expiry is one unit past the maximum count
  dslfs_timer #(.PRE(`DSLFS_MIT_UNIT), .LIMIT(`DSLFS_MIT_MAX + 1)) u_mit (
    .REF_CLK (REF_CLK),
    .RST_B   (RST_B),
    .clr     (act_reg != dslfs_pkg::ACT_TIMEOUT),
    .run     (1'b1),
    .tick    (BAUD_TICK),
    .done    (mit_done)
  );

  // ****************************************************************
  // frame sync machine
  // ****************************************************************
  always_comb begin
    sync_next = sync_reg;
    if (act_reg == dslfs_pkg::ACT_DEACT || act_reg == dslfs_pkg::ACT_INACTIVE) begin
      sync_next = dslfs_pkg::SYN_0;
    end else if (act_reg == dslfs_pkg::ACT_PEND_DEACT && deact_done) begin
      sync_next = dslfs_pkg::SYN_0;
    end else if (frame_step) begin
      case (sync_reg)
        dslfs_pkg::SYN_0: begin
          sync_next = FRAME_IN.frame_sync_word ? dslfs_pkg::SYN_0 : dslfs_pkg::SYN_1;
        end
        dslfs_pkg::SYN_1, dslfs_pkg::SYN_2, dslfs_pkg::SYN_3, dslfs_pkg::SYN_4,
        dslfs_pkg::SYN_5: begin
          if (FRAME_IN.frame_sync_word) begin
            sync_next = dslfs_pkg::SYN_0;
          end else begin
            sync_next = dslfs_pkg::dslfs_sync_t'(sync_reg + 4'h1);
          end
        end
        dslfs_pkg::SYN_6: begin
          if (FRAME_IN.frame_sync_word) begin
            sync_next = FRAME_IN.frame_alignment_changed ? dslfs_pkg::SYN_8
                                                         : dslfs_pkg::SYN_7;
          end
        end
        dslfs_pkg::SYN_7, dslfs_pkg::SYN_8: begin
          sync_next = FRAME_IN.frame_sync_word ? dslfs_pkg::SYN_0 : dslfs_pkg::SYN_6;
        end
        default: begin
          sync_next = dslfs_pkg::SYN_6;
        end
      endcase
    end
  end

  // ****************************************************************
  // activation machine
  // ****************************************************************
  always_comb begin
    act_next = act_reg;
    if (quiet && act_reg != dslfs_pkg::ACT_INACTIVE) begin
      act_next = dslfs_pkg::ACT_DEACT;
    end else begin
      case (act_reg)
        dslfs_pkg::ACT_INACTIVE: begin
          if (!quiet && master && ctrl_reg[`DSLFS_CTL_ACTIVATION_REQUEST]) begin
            act_next = dslfs_pkg::ACT_ACTIVATING;
          end else if (!quiet && !master && !SIGNAL_ABSENT) begin
            act_next = dslfs_pkg::ACT_ACTIVATING;
          end
        end
        dslfs_pkg::ACT_ACTIVATING: begin
          if (TRAIN_FAIL) begin
            act_next = dslfs_pkg::ACT_DEACT;
          end else if (TRAIN_DONE) begin
            act_next = framed ? dslfs_pkg::ACT_FRAMEDET : dslfs_pkg::ACT_ACTIVE;
          end
        end
        dslfs_pkg::ACT_FRAMEDET, dslfs_pkg::ACT_ACTIVE, dslfs_pkg::ACT_PEND_DEACT: begin
          if (BAUD_TICK && MARGIN_LOW) begin
            act_next = dslfs_pkg::ACT_TIMEOUT;
          end else if (act_reg == dslfs_pkg::ACT_PEND_DEACT && deact_done) begin
            act_next = dslfs_pkg::ACT_DEACT;
          end else if (sync_next == dslfs_pkg::SYN_6 && sync_reg == dslfs_pkg::SYN_5) begin
            act_next = dslfs_pkg::ACT_PEND_DEACT;
          end else if (act_reg != dslfs_pkg::ACT_ACTIVE && frame_step &&
                       sync_next == dslfs_pkg::SYN_0 && sync_reg != dslfs_pkg::SYN_0) begin
            act_next = dslfs_pkg::ACT_ACTIVE;
          end
        end
        dslfs_pkg::ACT_TIMEOUT: begin
          if (BAUD_TICK && MARGIN_OK) begin
            act_next = ret_reg;
          end else if (mit_done) begin
            act_next = dslfs_pkg::ACT_DEACT;
          end
        end
        dslfs_pkg::ACT_DEACT: begin
          if (!master && SIGNAL_ABSENT) begin
            act_next = dslfs_pkg::ACT_INACTIVE;
          end else if (master && los_done) begin
            act_next = dslfs_pkg::ACT_INACTIVE;
          end
        end
        default: begin
          act_next = dslfs_pkg::ACT_INACTIVE;
        end
      endcase
    end
  end

  // state update; time-out remembers where it came from
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      act_reg  <= dslfs_pkg::ACT_INACTIVE;
      ret_reg  <= dslfs_pkg::ACT_ACTIVE;
      sync_reg <= dslfs_pkg::SYN_6;
    end else begin
      act_reg <= act_next;
      if (act_next == dslfs_pkg::ACT_TIMEOUT && act_reg != dslfs_pkg::ACT_TIMEOUT) begin
        ret_reg <= act_reg;
      end
      // a fresh search always starts out of sync
      if (act_next == dslfs_pkg::ACT_FRAMEDET && act_reg == dslfs_pkg::ACT_ACTIVATING) begin
        sync_reg <= dslfs_pkg::SYN_6;
      end else if (act_reg != dslfs_pkg::ACT_TIMEOUT) begin
        sync_reg <= sync_next;
      end
    end
  end

  // ****************************************************************
  // loopbacks and receive polarity
  // ****************************************************************
  // analog loopback is latched only at a master's activation start
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      alb_reg <= 1'b0;
    end else if (act_reg == dslfs_pkg::ACT_INACTIVE) begin
      alb_reg <= (act_next == dslfs_pkg::ACT_ACTIVATING) && master &&
                 ctrl_reg[`DSLFS_CTL_ALB];
    end else if (act_next == dslfs_pkg::ACT_INACTIVE) begin
      alb_reg <= 1'b0;
    end
  end

  // framing polarity is learnt on each found sync word
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pol_reg <= 1'b0;
    end else if (framed && frame_step && FRAME_IN.frame_sync_word) begin
      pol_reg <= FRAME_IN.pol_neg;
    end
  end

  // line-facing outputs, all registered
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      TX_OUT        <= '0;
      RX_OUT        <= '0;
      RX_SIGN_OUT   <= 1'b0;
      TX_ENABLE     <= 1'b0;
      RX_INPUT_EN   <= 1'b1;
      BALANCE_EN    <= 1'b1;
      COEF_FREEZE   <= 1'b0;
      PHASE_REALIGN <= 1'b0;
      LINK_ACTIVE   <= 1'b0;
    end else begin
      TX_OUT        <= dlb_on ? RX_IN : TX_IN;
      RX_OUT        <= RX_IN;
      RX_SIGN_OUT   <= RX_SIGN_IN ^ (framed ? pol_reg : rev_reg[`DSLFS_REV_BIT]);
      TX_ENABLE     <= (act_next != dslfs_pkg::ACT_DEACT) &&
                       (act_next != dslfs_pkg::ACT_INACTIVE);
      RX_INPUT_EN   <= !alb_reg;
      BALANCE_EN    <= 1'b1;
      COEF_FREEZE   <= (act_next == dslfs_pkg::ACT_TIMEOUT);
      PHASE_REALIGN <= (act_reg == dslfs_pkg::ACT_TIMEOUT) &&
                       (act_next != dslfs_pkg::ACT_TIMEOUT) &&
                       (act_next != dslfs_pkg::ACT_DEACT);
      LINK_ACTIVE   <= (act_next == dslfs_pkg::ACT_ACTIVE) ||
                       (act_next == dslfs_pkg::ACT_PEND_DEACT);
    end
  end

  // ****************************************************************
  // host events
  // ****************************************************************
  // set beats a same-cycle write-one clear
  always_comb begin
    ev_next = ev_reg;
    if (wr_pend_reg && wr_addr_reg == `DSLFS_OFS_EVENTS) begin
      ev_next = ev_reg & ~HWDATA[2:0];
    end
    if (act_reg == dslfs_pkg::ACT_PEND_DEACT && ret_reg != dslfs_pkg::ACT_PEND_DEACT &&
        act_next == dslfs_pkg::ACT_PEND_DEACT) begin
      ev_next[`DSLFS_EV_OOS] = ev_next[`DSLFS_EV_OOS];
    end
    if (act_next == dslfs_pkg::ACT_PEND_DEACT && act_reg != dslfs_pkg::ACT_PEND_DEACT &&
        act_reg != dslfs_pkg::ACT_TIMEOUT) begin
      ev_next[`DSLFS_EV_OOS] = 1'b1;
    end
    if (act_next == dslfs_pkg::ACT_TIMEOUT && act_reg != dslfs_pkg::ACT_TIMEOUT) begin
      ev_next[`DSLFS_EV_TMO] = 1'b1;
    end
    if (act_next == dslfs_pkg::ACT_DEACT && act_reg != dslfs_pkg::ACT_DEACT) begin
      ev_next[`DSLFS_EV_DEACT] = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ev_reg <= 3'h0;
    end else begin
      ev_reg <= ev_next;
    end
  end

  // ****************************************************************
  // bus slave
  // ****************************************************************
  // zero wait states: hreadyout is high from the first clock after reset, answer is always okay
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      HREADYOUT <= 1'b0;
      HRESP     <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  // capture write address phase; data arrives one cycle later
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else begin
      wr_pend_reg <= addr_ok && HWRITE;
      wr_addr_reg <= HADDR[`DSLFS_ADDR_W-1:0];
    end
  end

  // writable registers, any write size takes the low byte
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_reg <= `DSLFS_RST_BYTE;
      rev_reg  <= `DSLFS_RST_BYTE;
      cfg_reg  <= `DSLFS_RST_CFG;
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        `DSLFS_OFS_MAIN_CTRL: ctrl_reg <= HWDATA[7:0];
        `DSLFS_OFS_IRQ_REV:   rev_reg  <= HWDATA[7:0];
        `DSLFS_OFS_CONFIG:    cfg_reg  <= HWDATA[7:0];
        default:              ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // read data prepared in the address phase, so hrdata is a flop
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      HRDATA <= 32'h0000_0000;
    end else if (addr_ok && !HWRITE) begin
      if (ctrl_reg[`DSLFS_CTL_DLB] && !framed) begin
        HRDATA <= 32'h0000_0000;
      end else begin
        case (HADDR[`DSLFS_ADDR_W-1:0])
          `DSLFS_OFS_MAIN_CTRL: HRDATA <= {24'h00_0000, ctrl_reg};
          `DSLFS_OFS_IRQ_REV:   HRDATA <= {24'h00_0000, rev_reg};
          `DSLFS_OFS_CONFIG:    HRDATA <= {24'h00_0000, cfg_reg};
          `DSLFS_OFS_STATUS:    HRDATA <= {20'h0_0000, pol_reg, COEF_FREEZE, dlb_on, alb_reg,
                                           1'b0, act_reg, sync_reg};
          `DSLFS_OFS_EVENTS:    HRDATA <= {29'h0000_0000, ev_reg};
          default:              HRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // dslfs_top

// ---- inc/dslfs_regs.svh ----
// register offsets, field positions, reset values and timing counts of the link keeper
`ifndef DSLFS_REGS_SVH
`define DSLFS_REGS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define DSLFS_OFS_MAIN_CTRL   8'h00
`define DSLFS_OFS_IRQ_REV     8'h08
`define DSLFS_OFS_CONFIG      8'h0C
`define DSLFS_OFS_STATUS      8'h10
`define DSLFS_OFS_EVENTS      8'h14
`define DSLFS_ADDR_W          8

// ****************************************************************
// field positions
// ****************************************************************
`define DSLFS_CTL_ACTIVATION_REQUEST      0
`define DSLFS_CTL_QUIET       1
`define DSLFS_CTL_ALB         5
`define DSLFS_CTL_DLB         6
`define DSLFS_REV_BIT         7
`define DSLFS_CFG_MODE_LSB    0
`define DSLFS_CFG_MODE_MSB    2
`define DSLFS_CFG_MASTER      3
`define DSLFS_CFG_HWCTL       4
`define DSLFS_EV_OOS          0
`define DSLFS_EV_TMO          1
`define DSLFS_EV_DEACT        2
`define DSLFS_ST_SYNC_LSB     0
`define DSLFS_ST_ACT_LSB      4
`define DSLFS_ST_ALB          8
`define DSLFS_ST_DLB          9
`define DSLFS_ST_FREEZE       10
`define DSLFS_ST_POLINV       11

// ****************************************************************
// reset values and constants
// ****************************************************************
`define DSLFS_RST_BYTE        8'h00
`define DSLFS_RST_CFG         8'h00
`define DSLFS_MODE_FR_A       3'h6
`define DSLFS_MODE_FR_B       3'h7
`define DSLFS_MIT_UNIT        2048
`define DSLFS_MIT_MAX         255
`define DSLFS_HTRANS_NONSEQ   2'h2
`define DSLFS_HTRANS_SEQ      2'h3

`endif

// ---- inc/dslfs_pkg.sv ----
// types shared by the link keeper files
package dslfs_pkg;

  // ****************************************************************
  // activation and frame sync states
  // ****************************************************************
  typedef enum logic [2:0] {
    ACT_INACTIVE   = 3'b000,
    ACT_ACTIVATING = 3'b001,
    ACT_FRAMEDET   = 3'b010,
    ACT_ACTIVE     = 3'b011,
    ACT_PEND_DEACT = 3'b100,
    ACT_TIMEOUT    = 3'b101,
    ACT_DEACT      = 3'b110
  } dslfs_act_t;

  typedef enum logic [3:0] {
    SYN_0 = 4'b0000, SYN_1 = 4'b0001, SYN_2 = 4'b0010,
    SYN_3 = 4'b0011, SYN_4 = 4'b0100, SYN_5 = 4'b0101,
    SYN_6 = 4'b0110, SYN_7 = 4'b0111, SYN_8 = 4'b1000
  } dslfs_sync_t;

  // one bit of data with its frame pulse
  typedef struct packed {
    logic data;
    logic fp;
  } dslfs_bit_t;

  // per-frame report from the sync word search
  typedef struct packed {
    logic tick;
    logic frame_sync_word;
    logic frame_alignment_changed;
    logic pol_neg;
  } dslfs_frame_t;

endpackage

// ---- verilog/dslfs_timer.sv ----
// prescaled up-counter with clear, used for the link keeper's timers
`timescale 1ns/1ps
module dslfs_timer #(
  parameter int PRE   = 1,
  parameter int LIMIT = 16
) (
  input  wire logic REF_CLK,
  input  wire logic RST_B,
  input  wire logic clr,
  input  wire logic run,
  input  wire logic tick,
  output logic      done
);
  localparam int PW = (PRE > 1) ? $clog2(PRE) : 1;
  localparam int CW = $clog2(LIMIT + 1);

  logic [PW-1:0] pre_reg;
  logic [CW-1:0] cnt_reg;

  // prescaler and unit count; clear wins over counting
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pre_reg <= '0;
      cnt_reg <= '0;
    end else if (clr) begin
      pre_reg <= '0;
      cnt_reg <= '0;
    end else if (run && tick && (cnt_reg != CW'(LIMIT))) begin
      if (pre_reg == PW'(PRE - 1)) begin
        pre_reg <= '0;
        cnt_reg <= cnt_reg + CW'(1);
      end else begin
        pre_reg <= pre_reg + PW'(1);
      end
    end
  end

  // done stands until cleared
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      done <= 1'b0;
    end else begin
      done <= !clr && (cnt_reg == CW'(LIMIT));
    end
  end
endmodule // dslfs_timer

// ---- sim/dslfs_properties.sv ----
// port-level checks of the link keeper
`timescale 1ns/1ps
module dslfs_properties (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic BAUD_TICK,
  input wire logic MARGIN_LOW,
  input wire logic MARGIN_OK,
  input wire logic TX_ENABLE,
  input wire logic BALANCE_EN,
  input wire logic COEF_FREEZE,
  input wire logic PHASE_REALIGN,
  input wire logic LINK_ACTIVE
);
  // two-cycle antecedents tolerate state versus output register skew
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  a_freeze_on_baud: assert property (
    $rose(COEF_FREEZE) |-> $past(BAUD_TICK) || $past(BAUD_TICK, 2)) else $error("freeze off baud");
  a_freeze_on_low: assert property (
    $rose(COEF_FREEZE) |-> $past(MARGIN_LOW)) else $error("freeze without low margin");
  a_freeze_not_link: assert property (
    COEF_FREEZE [*2] |-> !LINK_ACTIVE) else $error("link active while frozen");
  a_realign_once: assert property (
    PHASE_REALIGN |=> !PHASE_REALIGN) else $error("realign longer than one cycle");
  a_realign_on_ok: assert property (
    $rose(PHASE_REALIGN) |-> $past(MARGIN_OK)) else $error("realign without margin back");
  a_realign_unfreeze: assert property (
    PHASE_REALIGN |=> !COEF_FREEZE) else $error("still frozen after realign");
  a_silent_not_link: assert property (
    !TX_ENABLE [*2] |-> !LINK_ACTIVE) else $error("link active while silent");
  a_balance_kept_on: assert property (
    BALANCE_EN) else $error("balance input off");
endmodule // dslfs_properties

// ---- sim/dslfs_far_end.sv ----
// far-end transceiver: frame ends, received bits and signal presence
`timescale 1ns/1ps
module dslfs_far_end (
  input  wire logic                   clk,
  input  wire logic                   good,
  input  wire logic                   absent,
  input  wire logic                   alt,
  output dslfs_pkg::dslfs_frame_t     frame = '0,
  output dslfs_pkg::dslfs_bit_t       rx = '0,
  output logic                        sign = 1'h0,
  output logic                        sig_abs = 1'h1
);
  logic [3:0] cnt = 4'h0;
  // a frame every 16 clocks; bits change each cycle so stale data shows
  always @(posedge clk) begin
    cnt <= cnt + 4'h1;
    // alt marks both a realigned frame and a reversed framing polarity
    frame <= {cnt == 4'hF, good, alt, alt};
    rx <= {cnt[0], cnt[2]};
    sign <= cnt[1];
    sig_abs <= absent;
  end
endmodule // dslfs_far_end

// ---- sim/test_dsl_frame_sync_and_link_keepalive.sv ----
// self-checking bench of the link keeper with a far-end model
`timescale 1ns/1ps
`include "dslfs_regs.svh"
module test_dsl_frame_sync_and_link_keepalive;
  logic                    clk, rst_b, hsel, hwrite, baud, low, ok, td, good, absent;
  logic                    hready, hresp, sgn_in, sgn_out, tx_en, rx_en, bal, frz, rel;
  logic                    link, sig_abs, qp, tf, alt;
  logic [1:0]              htrans;
  logic [31:0]             haddr, hwdata, hrdata, rd;
  dslfs_pkg::dslfs_frame_t frame;
  dslfs_pkg::dslfs_bit_t   rx_in, tx_out, rx_out, tx_in;
  int                      bad_count, compares, cyc;
  // ******
  // clocks, design and far end
  // ******
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  dslfs_top #(.DEACT_FRAMES(4), .LOS_UNITS(2), .LOS_PRE(2)) dslfs_top_i (
    .REF_CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .QUIET_PIN(qp), .BAUD_TICK(baud),
    .FRAME_IN(frame), .MARGIN_LOW(low), .MARGIN_OK(ok), .SIGNAL_ABSENT(sig_abs),
    .TRAIN_DONE(td), .TRAIN_FAIL(tf), .RX_SIGN_IN(sgn_in), .TX_IN(tx_in),
    .RX_IN(rx_in), .TX_OUT(tx_out), .RX_OUT(rx_out), .RX_SIGN_OUT(sgn_out),
    .TX_ENABLE(tx_en), .RX_INPUT_EN(rx_en), .BALANCE_EN(bal), .COEF_FREEZE(frz),
    .PHASE_REALIGN(rel), .LINK_ACTIVE(link));
  dslfs_far_end dslfs_far_end_i (.clk(clk), .good(good), .absent(absent), .alt(alt),
    .frame(frame), .rx(rx_in), .sign(sgn_in), .sig_abs(sig_abs));
  // baud every 4 clocks; the ceiling cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    baud <= cyc[1:0] == 2'h3;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [6:0] e, input logic [6:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one single transfer; no wait count assumed, the ceiling ends a hang
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= `DSLFS_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge clk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'h1);
    rd = hrdata;
  endtask
  task automatic st(input logic [6:0] e);
    bus(1'h0, `DSLFS_OFS_STATUS, 32'h0);
    chk("status", e, rd[6:0]);
  endtask
  // set the sync word flag, let n frames pass, check act and sync
  task automatic fr(input logic g, input int n, input logic [6:0] e);
    good <= g;
    @(posedge clk); // the far end must sample the new flag first
    repeat (n) @(posedge clk iff frame.tick);
    @(posedge clk); // timer done flags land one clock late
    st(e);
  endtask
  task automatic train;
    absent <= 1'h0;
    repeat (4) @(posedge clk);
    td <= 1'h1;
    @(posedge clk);
    td <= 1'h0;
  endtask
  // line outputs lag their inputs by one clock
  task automatic lag(input logic lb, input logic inv);
    dslfs_pkg::dslfs_bit_t b;
    logic                  s;
    repeat (3) @(posedge clk);
    b = rx_in;
    s = sgn_in;
    #1;
    chk("tx_out", lb ? {5'h00, b} : {5'h00, tx_in}, {5'h00, tx_out});
    chk("rx_out", {5'h00, b}, {5'h00, rx_out});
    chk("rx_sign", {6'h00, s ^ inv}, {6'h00, sgn_out});
  endtask
  task automatic t_sync;
    bus(1'h1, `DSLFS_OFS_CONFIG, 32'h6);
    train;
    fr(1'h1, 1, 7'h27);
    fr(1'h1, 1, 7'h30);
    fr(1'h0, 1, 7'h31);
    fr(1'h1, 1, 7'h30);
    fr(1'h0, 5, 7'h35);
    fr(1'h0, 1, 7'h46);
    fr(1'h0, 4, 7'h60);
    fr(1'h0, 2, 7'h60);
    bus(1'h0, `DSLFS_OFS_EVENTS, 32'h0);
    chk("events", 7'h05, rd[6:0] & 7'h07);
    chk("hresp", 7'h00, {6'h00, hresp});
    bus(1'h1, `DSLFS_OFS_EVENTS, 32'h7);
    bus(1'h0, `DSLFS_OFS_EVENTS, 32'h0);
    chk("events_clr", 7'h00, rd[6:0]);
    absent <= 1'h1;
    fr(1'h0, 1, 7'h00);
    bus(1'h0, 8'h04, 32'h0);
    chk("unmapped", 7'h00, rd[6:0]);
  endtask
  task automatic t_link;
    alt <= 1'h1;
    train;
    fr(1'h1, 1, 7'h28);
    fr(1'h1, 1, 7'h30);
    bus(1'h1, `DSLFS_OFS_MAIN_CTRL, 32'h40);
    lag(1'h1, 1'h1);
    bus(1'h1, `DSLFS_OFS_MAIN_CTRL, 32'h0);
    low <= 1'h1;
    repeat (8) @(posedge clk);
    low <= 1'h0;
    st(7'h50);
    chk("freeze", 7'h01, {6'h00, frz});
    ok <= 1'h1;
    repeat (8) @(posedge clk);
    ok <= 1'h0;
    st(7'h30);
    bus(1'h1, `DSLFS_OFS_MAIN_CTRL, 32'h2);
    st(7'h60);
    chk("tx_enable", 7'h00, {6'h00, tx_en});
    bus(1'h1, `DSLFS_OFS_CONFIG, 32'h0);
    bus(1'h1, `DSLFS_OFS_IRQ_REV, 32'h80);
    lag(1'h0, 1'h1);
  endtask
  // master under pin control: absence wait, quiet pin, analog loopback
  task automatic t_alb;
    bus(1'h1, `DSLFS_OFS_CONFIG, 32'h18);
    absent <= 1'h1;
    repeat (24) @(posedge clk);
    st(7'h00);
    qp <= 1'h1;
    bus(1'h1, `DSLFS_OFS_MAIN_CTRL, 32'h21);
    st(7'h00);
    qp <= 1'h0;
    repeat (3) @(posedge clk);
    chk("rx_input_en", 7'h00, {6'h00, rx_en});
    chk("tx_enable", 7'h01, {6'h00, tx_en});
    tf <= 1'h1;
    @(posedge clk);
    tf <= 1'h0;
    st(7'h60);
  endtask
  // reset for six clocks, then the scenarios
  initial begin
    {rst_b, hsel, hwrite, low, ok, td, good, qp, tf, alt} = '0;
    {htrans, haddr, hwdata} = '0;
    absent = 1'h1;
    tx_in = 2'h2;
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    t_sync;
    t_link;
    t_alb;
    give_verdict;
  end
endmodule // test_dsl_frame_sync_and_link_keepalive
bind dslfs_top dslfs_properties dslfs_properties_i (.REF_CLK(REF_CLK), .RST_B(RST_B),
  .BAUD_TICK(BAUD_TICK), .MARGIN_LOW(MARGIN_LOW), .MARGIN_OK(MARGIN_OK),
  .TX_ENABLE(TX_ENABLE), .BALANCE_EN(BALANCE_EN), .COEF_FREEZE(COEF_FREEZE),
  .PHASE_REALIGN(PHASE_REALIGN), .LINK_ACTIVE(LINK_ACTIVE));
